// *** hw/flash_seq_pkg.sv ***
// Constants, carriers and state types of the flash sequencer and memory map
package flash_seq_pkg;

   // ***************************************************************
   // Register indices (byte address is four times the index)
   // ***************************************************************
   localparam logic [9:0]  SRAM_MAP_IDX     = 10'h0A7;
   localparam logic [9:0]  FLASH_CMD_IDX    = 10'h0A8;
   localparam logic [9:0]  FLASH_STATUS_IDX = 10'h0A9;
   localparam logic [9:0]  FLASH_PROT_IDX   = 10'h0AA;

   // ***************************************************************
   // Fields and reset values
   // ***************************************************************
   localparam int          MAP_BASE_BIT      = 2;
   localparam int          MAP_UPPER_BIT     = 1;
   localparam int          MAP_LOWER_BIT     = 0;
   localparam logic [2:0]  SRAM_MAP_RESET    = 3'h0;
   localparam int          FSR_BOOT_BIT      = 7;
   localparam int          FSR_WINDOW_BIT    = 6;
   localparam int          FSR_WEN_BIT       = 5;
   localparam int          FSR_NOT_READY_BIT = 4;
   localparam logic [5:0]  PROT_PAGES_RESET  = 6'h20;

   // ***************************************************************
   // Commands, address map and timing
   // ***************************************************************
   localparam logic [7:0]  UNLOCK_KEY_FIRST  = 8'hAA;
   localparam logic [7:0]  UNLOCK_KEY_SECOND = 8'h55;
   localparam logic [7:0]  LAST_CODE_PAGE    = 8'h1F;
   localparam logic [6:0]  UNLOCK_START      = 7'h7F;
   localparam logic [15:0] SRAM_BASE_HIGH    = 16'h8000;
   localparam logic [15:0] SRAM_SPAN         = 16'h0400;
   localparam logic [15:0] FLASH_CODE_TOP    = 16'h4000;
   localparam logic [15:0] NVM_BASE          = 16'hFC00;
   localparam logic [15:0] NVM_SPAN          = 16'h0400;
   localparam logic [14:0] NVM_FLASH_BASE    = 15'h4000;
   localparam logic [18:0] WRITE_CYCLES      = 19'h002E4;
   localparam int          ERASE_CYCLES_DEF  = 360000;

   // ***************************************************************
   // Carriers
   // ***************************************************************
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mcu_data_req_t;

   typedef struct packed {
      logic        write;
      logic        erase;
      logic [14:0] addr;
      logic [7:0]  wdata;
   } flash_req_t;

   typedef enum logic [1:0] {UNLOCK_IDLE, UNLOCK_FIRST, UNLOCK_SECOND} unlock_t;
   typedef enum logic [1:0] {OP_IDLE, OP_WRITE, OP_ERASE} flash_op_t;

   typedef struct packed {
      logic        boot_done;
      logic        prot_boot;
      unlock_t     unlock;
      logic [6:0]  window;
      logic        wen;
      flash_op_t   op;
      logic [18:0] op_count;
      logic [2:0]  map;
      logic [5:0]  prot_pages;
      logic [31:0] prdata;
      flash_req_t  flash;
      logic        data_hit;
      logic        data_half;
      logic        code_hit;
      logic        code_half;
      logic [14:0] code_flash_addr;
   } ctrl_state_t;

endpackage

// *** hw/sram_half_mem.sv ***
// One 512-byte SRAM half with registered read data
`timescale 1ns/10ps
module sram_half_mem
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       we,
   input  wire logic [8:0] waddr,
   input  wire logic [7:0] wdata,
   input  wire logic       re,
   input  wire logic [8:0] raddr,
   output logic      [7:0] rdata
);

   logic [7:0] mem [0:511];

   // No reset on the array: retention across power-down is the point
   always_ff @(posedge clk_sys)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata <= 8'h00;
      end
      else if (re)
      begin
         rdata <= mem[raddr];
      end
   end

endmodule

// *** hw/flash_memory_ctrl.sv ***
// Flash unlock and programming sequencer with boot and SRAM address mapping
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
module flash_memory_ctrl
#(
   parameter int ERASE_CYCLES = flash_seq_pkg::ERASE_CYCLES_DEF
)
(
   input  wire logic                          clk_sys,
   input  wire logic                          arst_n,
   input  wire logic [11:0]                   paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire flash_seq_pkg::mcu_data_req_t  data_req,
   output logic      [7:0]                    data_rdata,
   output logic                               data_sram_hit,
   input  wire logic                          code_fetch,
   input  wire logic [15:0]                   code_addr,
   output logic      [7:0]                    code_rdata,
   output logic                               code_sram_hit,
   output logic      [14:0]                   code_flash_addr,
   input  wire logic                          code_in_flash,
   input  wire logic [127:0]                  nv_tail_bytes,
   output logic                               cpu_stall,
   output logic                               irq_hold,
   output logic                               flash_not_ready,
   output flash_seq_pkg::flash_req_t          flash_req
);

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic [1:0] sram_lookup(input logic [15:0] addr, input logic [15:0] base);
      logic [15:0] off;
      off = addr - base;
      // Bit 1 hit, bit 0 half (upper when set)
      sram_lookup = {(addr >= base) && (off < flash_seq_pkg::SRAM_SPAN), off[9]};
   endfunction

   function automatic logic page_open(input logic [5:0] page, input logic [5:0] prot_pages);
      // Code pages from the protect config upward are locked, NV pages never
      page_open = (page > 6'h1F) || (page < prot_pages);
   endfunction

   function automatic logic reg_mapped(input logic [9:0] idx);
      reg_mapped = (idx == flash_seq_pkg::SRAM_MAP_IDX) ||
                   (idx == flash_seq_pkg::FLASH_CMD_IDX) ||
                   (idx == flash_seq_pkg::FLASH_STATUS_IDX) ||
                   (idx == flash_seq_pkg::FLASH_PROT_IDX);
   endfunction

   localparam logic [18:0] ERASE_LOAD = 19'(ERASE_CYCLES - 1);

   // ***************************************************************
   // Reset release
   // ***************************************************************
   logic [1:0] rst_sync;
   logic       rst_n;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_sync <= 2'b00;
      end
      else
      begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   assign rst_n = rst_sync[1];

   // ***************************************************************
   // State
   // ***************************************************************
   flash_seq_pkg::ctrl_state_t st;
   flash_seq_pkg::ctrl_state_t next_st;

   logic        busy;
   logic        prot_map;
   logic [15:0] sram_base;
   logic [1:0]  data_look;
   logic [1:0]  code_look;
   logic        lower_code;
   logic        upper_code;
   logic        data_in_sram;
   logic        code_in_sram;
   logic        reg_write;
   logic [9:0]  reg_idx;
   logic [7:0]  wbyte;
   logic [7:0]  status_byte;
   logic [5:0]  wr_page;
   logic [14:0] wr_flash_addr;
   logic        wr_in_flash;
   logic [7:0]  lower_rdata;
   logic [7:0]  upper_rdata;

   assign busy         = (st.op != flash_seq_pkg::OP_IDLE);
   assign prot_map     = st.prot_boot && st.boot_done;
   // and default base gives
   assign sram_base    = (prot_map || st.map[flash_seq_pkg::MAP_BASE_BIT]) ?
                         flash_seq_pkg::SRAM_BASE_HIGH : 16'h0000;
   assign data_look    = sram_lookup(data_req.addr, sram_base);
   assign code_look    = sram_lookup(code_addr, sram_base);
   assign lower_code   = st.map[flash_seq_pkg::MAP_LOWER_BIT];
   assign upper_code   = st.map[flash_seq_pkg::MAP_UPPER_BIT];
   assign data_in_sram = data_look[1] && !(data_look[0] ? upper_code : lower_code);
   assign code_in_sram = code_look[1] && (code_look[0] ? upper_code : lower_code);
   assign reg_idx      = paddr[11:2];
   assign reg_write    = psel && penable && pwrite;
   assign wbyte        = pwdata[7:0];
   assign status_byte  = {st.prot_boot,
                          (st.unlock == flash_seq_pkg::UNLOCK_SECOND),
                          st.wen, busy, 4'h0};

   // Memory address equals flash address; NV data sits above code pages
   always_comb
   begin
      wr_in_flash   = 1'b0;
      wr_flash_addr = data_req.addr[14:0];
      if (data_req.addr < flash_seq_pkg::FLASH_CODE_TOP)
      begin
         wr_in_flash = 1'b1;  // and
      end
      else if ((data_req.addr >= flash_seq_pkg::NVM_BASE) &&
               ((data_req.addr - flash_seq_pkg::NVM_BASE) < flash_seq_pkg::NVM_SPAN))
      begin
         wr_in_flash   = 1'b1;
         wr_flash_addr = flash_seq_pkg::NVM_FLASH_BASE + {5'h00, data_req.addr[9:0]};
      end
   end

   assign wr_page = wr_flash_addr[14:9];

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb
   begin
      next_st             = st;
      next_st.flash.write = 1'b0;
      next_st.flash.erase = 1'b0;

      // Parity of the NV tail picks the boot region once after reset
      if (!st.boot_done)
      begin
         next_st.boot_done = 1'b1;
         next_st.prot_boot = ^nv_tail_bytes;
      end

      // Unlock window counts down each cycle and closes at zero
      if (st.unlock != flash_seq_pkg::UNLOCK_IDLE)
      begin
         if (st.window == 7'h00)
         begin
            next_st.unlock = flash_seq_pkg::UNLOCK_IDLE;
         end
         else
         begin
            next_st.window = st.window - 7'h01;
         end
      end

      // Self-timed operation countdown
      if (busy)
      begin
         if (st.op_count == 19'h00000)
         begin
            next_st.op = flash_seq_pkg::OP_IDLE;
         end
         else
         begin
            next_st.op_count = st.op_count - 19'h00001;
         end
      end

      // CPU byte write into flash
      if (data_req.wr && !data_in_sram && wr_in_flash && st.wen && !busy &&
          page_open(wr_page, st.prot_pages))  // and
      begin
         next_st.flash.write = 1'b1;
         next_st.flash.addr  = wr_flash_addr;
         next_st.flash.wdata = data_req.wdata;
         next_st.op          = flash_seq_pkg::OP_WRITE;
         next_st.op_count    = flash_seq_pkg::WRITE_CYCLES - 19'h00001;
      end

      // Register writes take effect at the access edge
      if (reg_write)
      begin
         case (reg_idx)
            flash_seq_pkg::SRAM_MAP_IDX:
            begin
               next_st.map = wbyte[2:0];
            end
            flash_seq_pkg::FLASH_PROT_IDX:
            begin
               next_st.prot_pages = wbyte[5:0];
            end
            flash_seq_pkg::FLASH_STATUS_IDX:
            begin
               if (!wbyte[flash_seq_pkg::FSR_WEN_BIT])
               begin
                  next_st.wen = 1'b0;
               end
               else if (st.unlock == flash_seq_pkg::UNLOCK_SECOND)
               begin
                  next_st.wen = 1'b1;  // and
               end
            end
            flash_seq_pkg::FLASH_CMD_IDX:
            begin
               if (wbyte == flash_seq_pkg::UNLOCK_KEY_FIRST)
               begin
                  next_st.unlock = flash_seq_pkg::UNLOCK_FIRST;
                  next_st.window = flash_seq_pkg::UNLOCK_START;
               end
               else if ((wbyte == flash_seq_pkg::UNLOCK_KEY_SECOND) &&
                        (st.unlock == flash_seq_pkg::UNLOCK_FIRST))
               begin
                  next_st.unlock = flash_seq_pkg::UNLOCK_SECOND;
                  next_st.window = flash_seq_pkg::UNLOCK_START;
               end
               else if (wbyte <= flash_seq_pkg::LAST_CODE_PAGE)
               begin
                  // Same-cycle byte write wins
                  if (st.wen && !busy && !next_st.flash.write &&
                      page_open(wbyte[5:0], st.prot_pages))
                  begin
                     next_st.flash.erase = 1'b1;
                     next_st.flash.addr  = {wbyte[5:0], 9'h000};
                     next_st.op          = flash_seq_pkg::OP_ERASE;
                     next_st.op_count    = ERASE_LOAD;
                  end
               end
               else
               begin
                  next_st.unlock = flash_seq_pkg::UNLOCK_IDLE;
                  next_st.window = 7'h00;
               end
            end
            default:
            begin
               next_st.map = st.map;
            end
         endcase
      end

      // Read data is captured in the setup phase
      if (psel && !penable)
      begin
         case (reg_idx)
            flash_seq_pkg::SRAM_MAP_IDX:     next_st.prdata = {29'h0, st.map};
            flash_seq_pkg::FLASH_STATUS_IDX: next_st.prdata = {24'h0, status_byte};
            flash_seq_pkg::FLASH_PROT_IDX:   next_st.prdata = {26'h0, st.prot_pages};
            default:                         next_st.prdata = 32'h00000000;
         endcase
      end

      // Memory reads
      next_st.data_hit  = data_req.rd && data_in_sram;
      next_st.data_half = data_look[0];
      next_st.code_hit  = code_fetch && code_in_sram;
      next_st.code_half = code_look[0];
      if (code_fetch)
      begin
         // Protected pages start at the protect boundary; shift them to zero
         next_st.code_flash_addr = prot_map ?
                                   code_addr[14:0] + {st.prot_pages, 9'h000} :
                                   code_addr[14:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st            <= '0;
         st.unlock     <= flash_seq_pkg::UNLOCK_IDLE;
         st.op         <= flash_seq_pkg::OP_IDLE;
         st.map        <= flash_seq_pkg::SRAM_MAP_RESET;
         st.prot_pages <= flash_seq_pkg::PROT_PAGES_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ***************************************************************
   // SRAM halves
   // ***************************************************************
   // Lower half is the retained one
   sram_half_mem u_lower
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .we      (data_req.wr && data_in_sram && !data_look[0]),
      .waddr   (data_req.addr[8:0]),
      .wdata   (data_req.wdata),
      .re      (lower_code ? code_fetch : data_req.rd),
      .raddr   (lower_code ? code_addr[8:0] : data_req.addr[8:0]),
      .rdata   (lower_rdata)
   );

   sram_half_mem u_upper
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .we      (data_req.wr && data_in_sram && data_look[0]),
      .waddr   (data_req.addr[8:0]),
      .wdata   (data_req.wdata),
      .re      (upper_code ? code_fetch : data_req.rd),
      .raddr   (upper_code ? code_addr[8:0] : data_req.addr[8:0]),
      .rdata   (upper_rdata)
   );

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign prdata          = st.prdata;
   assign pready          = 1'b1;
   assign pslverr         = psel && penable && !reg_mapped(reg_idx);
   assign data_sram_hit   = st.data_hit;
   assign data_rdata      = st.data_half ? upper_rdata : lower_rdata;
   assign code_sram_hit   = st.code_hit;
   assign code_rdata      = st.code_half ? upper_rdata : lower_rdata;
   assign code_flash_addr = st.code_flash_addr;
   // Code outside flash keeps running and must poll; and
   assign cpu_stall       = busy && code_in_flash;
   assign irq_hold        = (st.op == flash_seq_pkg::OP_ERASE);
   assign flash_not_ready = busy;
   assign flash_req       = st.flash;

endmodule

// *** testbench/flash_ctrl_props.sv ***
// Port assertions for the flash sequencer, bound into its top module
`timescale 1ns/10ps
module flash_ctrl_props
#(
   parameter int ERASE_CYCLES = flash_seq_pkg::ERASE_CYCLES_DEF
)
(
   input wire logic                         clk_sys,
   input wire logic                         arst_n,
   input wire flash_seq_pkg::mcu_data_req_t data_req,
   input wire logic                         data_sram_hit,
   input wire logic                         code_in_flash,
   input wire logic                         cpu_stall,
   input wire logic                         irq_hold,
   input wire logic                         flash_not_ready,
   input wire flash_seq_pkg::flash_req_t    flash_req
);
   logic [18:0] busy_cnt;
   logic        was_erase;

   // **********
   // Busy length tracking
   // **********
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         busy_cnt <= 19'h00000;
         was_erase <= 1'b0;
      end
      else
      begin
         busy_cnt <= flash_not_ready ? busy_cnt + 19'h00001 : 19'h00000;
         if (flash_req.write || flash_req.erase)
            was_erase <= flash_req.erase;
      end
   end

   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   property p_busy_len;
      $fell(flash_not_ready) |->
         busy_cnt == (was_erase ? 19'(ERASE_CYCLES) : flash_seq_pkg::WRITE_CYCLES);
   endproperty
   a_busy_len: assert property (p_busy_len) // and
      else $error("busy time wrong");
   property p_wr_pulse;
      flash_req.write |-> flash_not_ready ##1 (!flash_req.write && flash_not_ready);
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write pulse wrong");
   property p_wr_src;
      flash_req.write |-> $past(data_req.wr) && !$past(flash_not_ready);
   endproperty
   a_wr_src: assert property (p_wr_src)
      else $error("write without cause");
   property p_erase_src;
      flash_req.erase |-> !$past(flash_not_ready) && flash_req.addr[8:0] == 9'h000;
   endproperty
   a_erase_src: assert property (p_erase_src)
      else $error("erase start wrong");
   property p_erase_busy;
      flash_req.erase |-> irq_hold && flash_not_ready;
   endproperty
   a_erase_busy: assert property (p_erase_busy)
      else $error("erase not holding");
   property p_irq;
      irq_hold |-> flash_not_ready && !flash_req.write;
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq hold outside erase");
   property p_stall;
      cpu_stall == (flash_not_ready && code_in_flash);
   endproperty
   a_stall: assert property (p_stall)
      else $error("stall mismatch");
   property p_sram_hit;
      data_sram_hit |-> $past(data_req.rd);
   endproperty
   a_sram_hit: assert property (p_sram_hit)
      else $error("sram hit without read");
endmodule

bind flash_memory_ctrl flash_ctrl_props #(.ERASE_CYCLES(ERASE_CYCLES)) u_props (.*);

// *** testbench/mcu_model.sv ***
// Behavioural MCU data and code port
`timescale 1ns/10ps
module mcu_model
(
   input  wire logic                    clk_sys,
   input  wire logic                    flash_not_ready,
   output flash_seq_pkg::mcu_data_req_t data_req,
   output logic                         code_fetch,
   output logic [15:0]                  code_addr
);
   initial
   begin
      data_req = '0;
      code_fetch = 1'b0;
      code_addr = 16'h0000;
   end

   // Idle lines show the inverse, so a stale value never passes
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      data_req <= {w, !w, a, d};
      @(posedge clk_sys);
      data_req <= {1'b0, 1'b0, ~a, ~d};
   endtask

   task automatic fetch(input logic [15:0] a);
      @(posedge clk_sys);
      code_fetch <= 1'b1;
      code_addr <= a;
      @(posedge clk_sys);
      code_fetch <= 1'b0;
      code_addr <= ~a;
   endtask

   // Code outside flash polls until flash_not_ready falls; only the bench watchdog ends a stuck wait
   task automatic wait_ready(output int n);
      n = 0;
      while (flash_not_ready === 1'b1)
      begin
         @(posedge clk_sys);
         n++;
      end
   endtask
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the flash sequencer and memory map
`timescale 1ns/10ps
module tb;
   localparam int                ERASE_N = 20;
   localparam logic [11:0]       A_MAP = {flash_seq_pkg::SRAM_MAP_IDX, 2'h0};
   localparam logic [11:0]       A_CMD = {flash_seq_pkg::FLASH_CMD_IDX, 2'h0};
   localparam logic [11:0]       A_ST = {flash_seq_pkg::FLASH_STATUS_IDX, 2'h0};
   localparam logic [11:0]       A_PROT = {flash_seq_pkg::FLASH_PROT_IDX, 2'h0};
   localparam logic [11:0]       A_BAD = 12'h2AC;
   logic                         clk_sys;
   logic                         arst_n;
   logic [11:0]                  paddr;
   logic                         psel;
   logic                         penable;
   logic                         pwrite;
   logic [31:0]                  pwdata;
   logic [31:0]                  prdata;
   logic                         pready;
   logic                         pslverr;
   flash_seq_pkg::mcu_data_req_t data_req;
   logic [7:0]                   data_rdata;
   logic                         data_sram_hit;
   logic                         code_fetch;
   logic [15:0]                  code_addr;
   logic [7:0]                   code_rdata;
   logic                         code_sram_hit;
   logic [14:0]                  code_flash_addr;
   logic                         code_in_flash;
   logic [127:0]                 nv_tail_bytes;
   logic                         cpu_stall;
   logic                         irq_hold;
   logic                         flash_not_ready;
   flash_seq_pkg::flash_req_t    flash_req;
   logic [31:0]                  rd;
   logic                         err;
   int                           n_fail = 0;
   int                           n_checks = 0;
   int                           cyc = 0;

   flash_memory_ctrl #(.ERASE_CYCLES(ERASE_N)) dut (.*);
   mcu_model mcu (.*);

   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // **********
   // Shared tasks
   // **********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   task automatic do_reset;
      arst_n <= 1'b0;
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic unlock;
      wr(A_CMD, 32'hAA);
      wr(A_CMD, 32'h55);
      wr(A_ST, 32'h20);
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   // **********
   // Scenarios
   // **********
   task automatic t_regs;
      rdchk(A_MAP, 32'h0);
      rdchk(A_PROT, 32'h20);
      wr(A_MAP, 32'hFF);
      rdchk(A_MAP, 32'h7);
      apb(1'b0, A_BAD, 32'h0);
      chk({31'h0, err}, 32'h1);
      wr(A_MAP, 32'h0);
      done("regs");
   endtask

   task automatic t_lock;
      wr(A_ST, 32'h20);
      rdchk(A_ST, 32'h0);
      wr(A_CMD, 32'hAA);
      wr(A_ST, 32'h20);
      rdchk(A_ST, 32'h0);
      wr(A_CMD, 32'h33);
      wr(A_CMD, 32'h55);
      rdchk(A_ST, 32'h0);
      wr(A_CMD, 32'hAA);
      wr(A_CMD, 32'h55);
      rdchk(A_ST, 32'h40);
      repeat (130) @(posedge clk_sys);
      wr(A_ST, 32'h20);
      rdchk(A_ST, 32'h0);
      done("lock");
   endtask

   task automatic t_write;
      int n;
      code_in_flash <= 1'b1;
      unlock();
      rdchk(A_ST, 32'h60);
      mcu.acc(1'b1, 16'h0A23, 8'h5A);
      @(posedge clk_sys);
      chk({flash_req.write, flash_req.addr, flash_req.wdata, cpu_stall},
          {1'b1, 15'h0A23, 8'h5A, 1'b1}); // and
      mcu.wait_ready(n);
      chk(32'(n), 32'(flash_seq_pkg::WRITE_CYCLES));
      // A second write while busy must be dropped, not queued
      mcu.acc(1'b1, 16'h0A24, 8'h11);
      mcu.acc(1'b1, 16'h0A25, 8'h22);
      @(posedge clk_sys);
      chk({flash_req.write, flash_req.addr}, {1'b0, 15'h0A24});
      mcu.wait_ready(n);
      wr(A_ST, 32'h0);
      mcu.acc(1'b1, 16'h0A26, 8'h33);
      @(posedge clk_sys);
      chk({flash_req.write, cpu_stall}, 32'h0); // and
      code_in_flash <= 1'b0;
      done("write");
   endtask

   task automatic t_erase;
      int n;
      unlock();
      for (int p = 0; p < 32; p += 31)
      begin
         wr(A_CMD, 32'(p));
         @(posedge clk_sys);
         chk({flash_req.erase, irq_hold, flash_req.addr}, {2'h3, 6'(p), 9'h000});
         mcu.wait_ready(n);
         chk(32'(n), 32'(ERASE_N));
      end
      wr(A_PROT, 32'h5);
      wr(A_CMD, 32'h5);
      @(posedge clk_sys);
      chk({31'h0, flash_req.erase}, 32'h0); // and
      mcu.acc(1'b1, 16'h0A00, 8'h44);
      @(posedge clk_sys);
      chk({31'h0, flash_req.write}, 32'h0);
      mcu.acc(1'b1, 16'h0800, 8'h55);
      @(posedge clk_sys);
      chk({31'h0, flash_req.write}, 32'h1);
      mcu.wait_ready(n);
      wr(A_ST, 32'h0);
      wr(A_PROT, 32'h20);
      done("erase");
   endtask

   task automatic t_sram;
      mcu.acc(1'b1, 16'h0010, 8'hC3);
      mcu.acc(1'b0, 16'h0010, 8'h00);
      @(posedge clk_sys);
      chk({data_sram_hit, data_rdata}, {1'b1, 8'hC3});
      wr(A_MAP, 32'h4);
      mcu.acc(1'b0, 16'h8010, 8'h00);
      @(posedge clk_sys);
      chk({data_sram_hit, data_rdata}, {1'b1, 8'hC3});
      mcu.acc(1'b0, 16'h0010, 8'h00);
      @(posedge clk_sys);
      chk({31'h0, data_sram_hit}, 32'h0);
      mcu.acc(1'b1, 16'h8210, 8'h3C);
      wr(A_MAP, 32'h5);
      mcu.fetch(16'h8010);
      @(posedge clk_sys);
      chk({code_sram_hit, code_rdata}, {1'b1, 8'hC3});
      mcu.fetch(16'h8210);
      @(posedge clk_sys);
      chk({31'h0, code_sram_hit}, 32'h0);
      mcu.acc(1'b0, 16'h8210, 8'h00);
      @(posedge clk_sys);
      chk({data_sram_hit, data_rdata}, {1'b1, 8'h3C});
      mcu.fetch(16'h0123);
      @(posedge clk_sys);
      chk({17'h0, code_flash_addr}, 32'h0123);
      wr(A_MAP, 32'h0);
      done("sram");
   endtask

   task automatic t_boot;
      nv_tail_bytes <= 128'h1;
      do_reset();
      rdchk(A_ST, 32'h80);
      wr(A_PROT, 32'h4);
      mcu.fetch(16'h0010);
      @(posedge clk_sys);
      chk({17'h0, code_flash_addr}, 32'h0810);
      mcu.acc(1'b1, 16'h8005, 8'h99);
      mcu.acc(1'b0, 16'h8005, 8'h00);
      @(posedge clk_sys);
      chk({data_sram_hit, data_rdata}, {1'b1, 8'h99});
      unlock();
      mcu.acc(1'b1, 16'h0100, 8'h77);
      @(posedge clk_sys);
      chk({31'h0, flash_req.write}, 32'h1);
      nv_tail_bytes <= 128'h3;
      do_reset();
      rdchk(A_ST, 32'h0);
      done("boot");
   endtask

   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Well above the few thousand cycles the scenarios need
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 10000)
      begin
         n_fail++;
         end_of_test();
      end
   end

   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      code_in_flash = 1'b0;
      nv_tail_bytes = '0;
      arst_n = 1'b0;
      do_reset();
      t_regs();
      t_lock();
      t_write();
      t_erase();
      t_sram();
      t_boot();
      end_of_test();
   end
endmodule
